// >>> hdl/ccdlt_pkg.sv
package ccdlt_pkg;
  localparam int CHANNELS = 3;
  localparam int PIXELS_FULL = 2098;
  localparam int CHARGE_WIDTH = 16;
  localparam int INDEX_WIDTH = 12;
  localparam int EXPOSURE_WIDTH = 24;
  localparam int FIFO_DEPTH = 4;
  localparam logic [CHARGE_WIDTH-1:0] FULL_WELL = 16'hFFFF;
  localparam logic [CHARGE_WIDTH-1:0] CHARGE_EMPTY = 16'h0000;
  localparam logic [EXPOSURE_WIDTH-1:0] EXPOSURE_MAX = 24'hFFFFFF;
  localparam logic [EXPOSURE_WIDTH-1:0] EXPOSURE_ZERO = 24'h000000;
  localparam logic [INDEX_WIDTH-1:0] INDEX_ZERO = 12'h000;
  localparam logic [INDEX_WIDTH-1:0] INDEX_ONE = 12'h001;

  typedef logic [CHARGE_WIDTH-1:0] ccdlt_charge_type;

  typedef struct packed {
    logic [INDEX_WIDTH-1:0] index;
    ccdlt_charge_type [CHANNELS-1:0] charge;
  } ccdlt_pixel_type;

  typedef struct packed {
    logic phase1;
    logic phase2;
    logic summing_gate_clock;
    logic reset_clock;
    logic inner_transfer_gate;
    logic outer_transfer_gate;
    logic [CHANNELS-1:0] exposure_drain;
  } ccdlt_clocks_type;

  localparam ccdlt_clocks_type CLOCKS_IDLE = '0;

  typedef enum logic [1:0] {
    ST_READOUT = 2'b00,
    ST_GATES_OPEN = 2'b01,
    ST_CHARGE_MOVE = 2'b10
  } ccdlt_state_type;

  // Wells clip at full well instead of wrapping
  function automatic ccdlt_charge_type ccdlt_sat_add(
    input ccdlt_charge_type a,
    input ccdlt_charge_type b
  );
    logic [CHARGE_WIDTH:0] sum;
    sum = {1'b0, a} + {1'b0, b};
    return sum[CHARGE_WIDTH] ? FULL_WELL : sum[CHARGE_WIDTH-1:0];
  endfunction
endpackage

// >>> hdl/ccdlt_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module ccdlt_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);
  localparam logic [CW-1:0] ONE = CW'(1);

  // Head always sits in slot 0 so the output is a plain flop
  logic [WIDTH-1:0] mem [DEPTH];
  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  logic [CW-1:0] write_slot;
  logic push;
  logic pop;

  assign in_ready = (count != FULL);
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign write_slot = pop ? count - ONE : count;
  assign next_count = count + (push ? ONE : '0) - (pop ? ONE : '0);
  assign out_data = mem[0];

  genvar i;
  generate
    for (i = 0; i < DEPTH; i++) begin : g_slot
      always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
          mem[i] <= '0;
        end else if (push && write_slot == CW'(i)) begin
          mem[i] <= in_data;
        end else if (pop && i < DEPTH - 1) begin
          mem[i] <= mem[(i + 1) % DEPTH];
        end
      end
    end
  endgenerate

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      count <= '0;
      out_valid <= 1'b0;
    end else begin
      count <= next_count;
      out_valid <= (next_count != '0);
    end
  end
endmodule
`default_nettype wire

// >>> hdl/ccdlt_sensor.sv
`timescale 1ns/10ps
`default_nettype none
module ccdlt_sensor #(
  parameter int PIXELS = ccdlt_pkg::PIXELS_FULL
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire ccdlt_pkg::ccdlt_clocks_type clocks,
  input wire ccdlt_pkg::ccdlt_charge_type [ccdlt_pkg::CHANNELS-1:0] photo_flux,
  output ccdlt_pkg::ccdlt_pixel_type pixel_data,
  output logic pixel_valid,
  input wire logic pixel_ready,
  output logic pixel_dropped,
  output logic [ccdlt_pkg::CHANNELS-1:0][ccdlt_pkg::EXPOSURE_WIDTH-1:0]
    effective_exposure_time
);
  import ccdlt_pkg::*;

  localparam logic [INDEX_WIDTH-1:0] LINE_PIXELS = INDEX_WIDTH'(PIXELS);

  ccdlt_clocks_type last;
  ccdlt_state_type state;
  ccdlt_state_type next_state;
  ccdlt_charge_type [CHANNELS-1:0] diode;
  ccdlt_charge_type [CHANNELS-1:0] storage;
  ccdlt_charge_type [CHANNELS-1:0] line;
  ccdlt_charge_type [CHANNELS-1:0] summed;
  ccdlt_charge_type [CHANNELS-1:0] sense;
  ccdlt_charge_type [CHANNELS-1:0] dumped;
  logic [CHANNELS-1:0][EXPOSURE_WIDTH-1:0] exposure_count;
  logic [INDEX_WIDTH-1:0] remaining;
  logic [INDEX_WIDTH-1:0] out_index;
  logic summed_holds;
  ccdlt_pixel_type pending;
  logic pending_valid;
  logic fifo_ready;
  logic push_taken;

  wire phase2_rise = clocks.phase2 & ~last.phase2;
  wire summing_fall = ~clocks.summing_gate_clock & last.summing_gate_clock;
  wire reset_rise = clocks.reset_clock & ~last.reset_clock;
  wire inner_fall = ~clocks.inner_transfer_gate & last.inner_transfer_gate;
  wire gates_closed = ~clocks.inner_transfer_gate
    & ~clocks.outer_transfer_gate;
  wire phases_parked = clocks.phase1 & ~clocks.phase2;
  wire gates_open = clocks.inner_transfer_gate & clocks.outer_transfer_gate;
  wire line_load = (state == ST_GATES_OPEN) & inner_fall
    & clocks.outer_transfer_gate;
  wire shift_step = (state == ST_READOUT) & gates_closed & phase2_rise;
  wire shift_real = shift_step & (remaining != INDEX_ZERO);
  wire dump_step = summing_fall & summed_holds;
  wire collide = dump_step & pending_valid & ~push_taken;

  assign push_taken = pending_valid & fifo_ready;

  always_comb begin
    next_state = state;
    unique case (state)
      ST_READOUT:
        if (gates_open && phases_parked) next_state = ST_GATES_OPEN;
      ST_GATES_OPEN:
        if (line_load) next_state = ST_CHARGE_MOVE;
        else if (!clocks.outer_transfer_gate) next_state = ST_READOUT;
      ST_CHARGE_MOVE:
        if (!clocks.outer_transfer_gate) next_state = ST_READOUT;
      default: next_state = ST_READOUT;
    endcase
  end

  genvar c;
  generate
    for (c = 0; c < CHANNELS; c++) begin : g_chan
      wire draining = clocks.exposure_drain[c] & ~clocks.inner_transfer_gate;
      wire ccdlt_charge_type transferred = ccdlt_sat_add(storage[c], diode[c]);
      assign dumped[c] = ccdlt_sat_add(reset_rise ? CHARGE_EMPTY : sense[c],
        summed[c]);

      always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
          diode[c] <= CHARGE_EMPTY;
          storage[c] <= CHARGE_EMPTY;
          line[c] <= CHARGE_EMPTY;
        end else begin
          if (state == ST_GATES_OPEN || draining) diode[c] <= CHARGE_EMPTY;
          else diode[c] <= ccdlt_sat_add(diode[c], photo_flux[c]);
          if (line_load) storage[c] <= CHARGE_EMPTY;
          else if (state == ST_GATES_OPEN) storage[c] <= transferred;
          if (line_load) line[c] <= transferred;
        end
      end

      always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
          summed[c] <= CHARGE_EMPTY;
          sense[c] <= CHARGE_EMPTY;
        end else begin
          // packets add until the summing gate falls
          if (summing_fall) summed[c] <= CHARGE_EMPTY;
          else if (shift_real) summed[c] <= ccdlt_sat_add(summed[c], line[c]);
          // fall moves packet to sense node
          if (summing_fall) sense[c] <= dumped[c];
          else if (reset_rise) sense[c] <= CHARGE_EMPTY;
        end
      end

      // count from overflow fall, latch at inner fall
      always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
          exposure_count[c] <= EXPOSURE_ZERO;
          effective_exposure_time[c] <= EXPOSURE_ZERO;
        end else begin
          if (inner_fall) effective_exposure_time[c] <= exposure_count[c];
          if (draining || inner_fall) exposure_count[c] <= EXPOSURE_ZERO;
          else if (exposure_count[c] != EXPOSURE_MAX)
            exposure_count[c] <= exposure_count[c] + 1'b1;
        end
      end
    end
  endgenerate

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      last <= CLOCKS_IDLE;
      state <= ST_READOUT;
    end else begin
      last <= clocks;
      state <= next_state;
    end
  end

  // all channels shift on each phase2 rise in ST_READOUT with both gates closed, while pixels remain
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      remaining <= INDEX_ZERO;
      out_index <= INDEX_ZERO;
      summed_holds <= 1'b0;
    end else begin
      if (line_load) remaining <= LINE_PIXELS;
      else if (shift_real) remaining <= remaining - INDEX_ONE;
      if (line_load) out_index <= INDEX_ZERO;
      else if (dump_step) out_index <= out_index + INDEX_ONE;
      if (summing_fall) summed_holds <= 1'b0;
      else if (shift_real) summed_holds <= 1'b1;
    end
  end

  // One word waits here while the FIFO is full; a second one overwrites it and the waiting one is lost
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pending <= '0;
      pending_valid <= 1'b0;
      pixel_dropped <= 1'b0;
    end else begin
      pixel_dropped <= collide;
      if (dump_step) begin
        pending.index <= out_index;
        pending.charge <= dumped;
        pending_valid <= 1'b1;
      end else if (push_taken) begin
        pending_valid <= 1'b0;
      end
    end
  end

  ccdlt_fifo #(
    .WIDTH($bits(ccdlt_pixel_type)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .reset_n(reset_n),
    .in_data(pending),
    .in_valid(pending_valid),
    .in_ready(fifo_ready),
    .out_data(pixel_data),
    .out_valid(pixel_valid),
    .out_ready(pixel_ready)
  );

  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  sequence s_line_load;
    state == ST_GATES_OPEN && inner_fall && clocks.outer_transfer_gate;
  endsequence

  sequence s_line_ready;
    state == ST_CHARGE_MOVE && remaining == LINE_PIXELS;
  endsequence

  a_line_load_move: assert property (
    s_line_load |=> s_line_ready)
    else $error("line load did not arm readout");

  a_gates_empty_diode: assert property (
    state == ST_GATES_OPEN |=> diode[0] == CHARGE_EMPTY)
    else $error("diode not emptied while gates open");

  a_shift_count_down: assert property (
    shift_real && !line_load |=> remaining == $past(remaining) - INDEX_ONE)
    else $error("shift did not advance register");

  a_dump_to_pending: assert property (
    dump_step |=> pending_valid && pending.charge[0] == $past(dumped[0]))
    else $error("summing gate fall lost packet");

  a_drain_clears_diode: assert property (
    clocks.exposure_drain[1] && !clocks.inner_transfer_gate
    |=> diode[1] == CHARGE_EMPTY)
    else $error("overflow gate did not drain");

  a_exposure_latched: assert property (
    inner_fall |=> effective_exposure_time[2] == $past(exposure_count[2])
      && exposure_count[2] == EXPOSURE_ZERO)
    else $error("exposure not latched at inner fall");

  a_reset_clears_sense: assert property (
    reset_rise && !summing_fall |=> sense[0] == CHARGE_EMPTY)
    else $error("reset clock left sense node charged");

  a_pending_drains: assert property (
    pending_valid && fifo_ready && !dump_step |=> !pending_valid)
    else $error("pending word not handed to FIFO");
endmodule
`default_nettype wire

// >>> verif/ccdlt_gen.sv
`timescale 1ns/10ps
`default_nettype none
module ccdlt_gen #(
  parameter int PIXELS = 8
) (
  input wire logic clock,
  output ccdlt_pkg::ccdlt_clocks_type clocks
);
  import ccdlt_pkg::*;
  int t_now = 0;
  int t_fall = 0;
  int t_rel[CHANNELS];

  always @(posedge clock) t_now <= t_now + 1;

  initial clocks = CLOCKS_IDLE;

  task automatic step(input int n);
    repeat (n) @(negedge clock);
  endtask

  task automatic transfer(input logic parked);
    clocks.phase1 = parked;
    clocks.phase2 = 1'b0;
    step(2);
    clocks.inner_transfer_gate = 1'b1;
    clocks.outer_transfer_gate = 1'b1;
    // Held drains end here, so exposure never runs unbounded
    for (int c = 0; c < CHANNELS; c++)
      if (clocks.exposure_drain[c])
        t_rel[c] = t_now;
    clocks.exposure_drain = '0;
    step(2);
    clocks.inner_transfer_gate = 1'b0;
    clocks.exposure_drain = '1;
    t_fall = t_now;
    step(2);
    clocks.outer_transfer_gate = 1'b0;
    step(2);
  endtask

  task automatic readout(input logic summing, input int drop[CHANNELS]);
    for (int p = 0; p < PIXELS; p++) begin
      for (int c = 0; c < CHANNELS; c++)
        if (drop[c] == p) begin
          clocks.exposure_drain[c] = 1'b0;
          t_rel[c] = t_now;
        end
      clocks.reset_clock = !summing || !p[0];
      clocks.phase1 = 1'b0;
      clocks.phase2 = 1'b1;
      clocks.summing_gate_clock = 1'b1;
      step(1);
      clocks.reset_clock = 1'b0;
      clocks.phase1 = 1'b1;
      clocks.phase2 = 1'b0;
      clocks.summing_gate_clock = summing && !p[0];
      step(1);
    end
  endtask
endmodule
`default_nettype wire

// >>> verif/ccdlt_sensor_test.sv
`timescale 1ns/10ps
`default_nettype none
module ccdlt_sensor_test;
  import ccdlt_pkg::*;
  localparam int PIX = 8;
  localparam int GAP = 10;
  localparam int HOLD = 99;
  typedef struct {
    logic summing;
    int drop[CHANNELS];
    ccdlt_charge_type flux[CHANNELS];
    ccdlt_charge_type charge[CHANNELS];
  } ccdlt_row_type;
  ccdlt_row_type rows[3];
  int none[CHANNELS] = '{HOLD, HOLD, HOLD};
  logic clock = 1'b0;
  logic reset_n;
  ccdlt_clocks_type clocks;
  ccdlt_charge_type [CHANNELS-1:0] photo_flux;
  ccdlt_pixel_type pixel_data;
  logic pixel_valid;
  logic pixel_ready;
  logic pixel_dropped;
  logic [CHANNELS-1:0][EXPOSURE_WIDTH-1:0] effective_exposure_time;
  ccdlt_pixel_type got[$];
  int n_mismatch = 0;
  int checked = 0;
  int cycles = 0;
  int drops = 0;
  logic prev_sum = 1'b0;

  always #4 clock = ~clock;

  ccdlt_gen #(.PIXELS(PIX)) ccdlt_gen_i (.clock(clock), .clocks(clocks));
  ccdlt_sensor #(.PIXELS(PIX)) ccdlt_sensor_i (
    .clock(clock), .reset_n(reset_n), .clocks(clocks),
    .photo_flux(photo_flux), .pixel_data(pixel_data),
    .pixel_valid(pixel_valid), .pixel_ready(pixel_ready),
    .pixel_dropped(pixel_dropped),
    .effective_exposure_time(effective_exposure_time)
  );

  task automatic complete_run();
    $display("checked %0d, n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  always @(posedge clock) begin
    cycles++;
    if (pixel_valid === 1'b1 && pixel_ready === 1'b1)
      got.push_back(pixel_data);
    if (pixel_dropped === 1'b1)
      drops++;
    if (cycles == 5000) begin
      n_mismatch++;
      complete_run();
    end
  end

  task automatic check(input logic [79:0] value, input logic [79:0] want);
    checked++;
    if (value !== want) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h, expected %h", $time, value, want);
    end
  endtask

  task automatic wait_words(input int n);
    for (int i = 0; i < 40 && got.size() < n; i++)
      @(negedge clock);
    repeat (4) @(negedge clock);
  endtask

  task automatic check_line(input ccdlt_row_type row);
    int n;
    n = row.summing ? PIX / 2 : PIX;
    wait_words(n);
    check(got.size(), n);
    foreach (got[i]) begin
      check(got[i].index, i);
      for (int c = 0; c < CHANNELS; c++)
        check(got[i].charge[c], row.charge[c]);
    end
    got.delete();
  endtask

  initial begin
    int want;
    reset_n = 1'b0;
    pixel_ready = 1'b1;
    photo_flux = '0;
    rows[0] = '{1'b0, '{0, 3, HOLD}, '{16'h0010, 16'h0003, 16'h0100},
      '{16'h00A0, 16'h001E, 16'h0000}};
    rows[1] = '{1'b1, '{7, HOLD, 0}, '{16'h0700, 16'h0005, 16'h0001},
      '{16'h8C00, 16'h0000, 16'h0014}};
    rows[2] = '{1'b0, '{HOLD, 0, 1}, '{16'h0001, 16'h2000, 16'hFFFF},
      '{16'h0000, 16'hFFFF, 16'hFFFF}};
    repeat (20) @(negedge clock);
    reset_n = 1'b1;
    @(negedge clock);
    ccdlt_gen_i.transfer(1'b1);
    foreach (rows[r]) begin
      ccdlt_gen_i.readout(prev_sum, rows[r].drop);
      if (r > 0)
        check_line(rows[r - 1]);
      else begin
        wait_words(PIX);
        got.delete();
      end
      for (int c = 0; c < CHANNELS; c++)
        photo_flux[c] = rows[r].flux[c];
      repeat (GAP) @(negedge clock);
      photo_flux = '0;
      ccdlt_gen_i.transfer(1'b1);
      for (int c = 0; c < CHANNELS; c++) begin
        want = ccdlt_gen_i.t_fall - ccdlt_gen_i.t_rel[c];
        check(effective_exposure_time[c], want);
      end
      prev_sum = rows[r].summing;
    end
    ccdlt_gen_i.readout(prev_sum, none);
    check_line(rows[2]);
    // Backpressure: FIFO plus one pending word, each later dump overwrites the pending one
    ccdlt_gen_i.transfer(1'b1);
    pixel_ready = 1'b0;
    ccdlt_gen_i.readout(1'b0, none);
    repeat (6) @(negedge clock);
    check(drops, PIX - FIFO_DEPTH - 1);
    pixel_ready = 1'b1;
    wait_words(FIFO_DEPTH + 1);
    check(got.size(), FIFO_DEPTH + 1);
    check(got[FIFO_DEPTH].index, PIX - 1);
    got.delete();
    // Unparked phases: no line may load
    ccdlt_gen_i.transfer(1'b0);
    ccdlt_gen_i.readout(1'b0, none);
    wait_words(1);
    check(got.size(), 0);
    reset_n = 1'b0;
    repeat (2) @(negedge clock);
    check(pixel_valid, 0);
    check(effective_exposure_time, 0);
    reset_n = 1'b1;
    // Outputs must stay quiet over the first edges after release
    repeat (2) @(negedge clock);
    check(pixel_valid, 0);
    check(effective_exposure_time, 0);
    complete_run();
  end
endmodule
`default_nettype wire
